// file: core/cblf_regs.svh
// Constants of the configuration byte loader front end
`ifndef CBLF_REGS_SVH
`define CBLF_REGS_SVH

// Address counter start values
`define CBLF_ADDR_UP_START    18'h00000
`define CBLF_ADDR_DOWN_START  18'h3FFFF
`define CBLF_ADDR_STEP        18'h00001

// Bits shifted per byte
`define CBLF_BITS_PER_BYTE    4'h8

// Configuration clock half periods in link clock cycles (ratio 8)
`define CBLF_HALF_FAST        4'h1
`define CBLF_HALF_SLOW        4'h8

// Settling time before the first memory byte is read
`define CBLF_ADDR_SETTLE      4'hF

// Initialization phase after power-up or restart
`define CBLF_CLK_PERIOD_NS    8
`define CBLF_INIT_TIME_NS     1000
`define CBLF_INIT_CYCLES      8'((`CBLF_INIT_TIME_NS + `CBLF_CLK_PERIOD_NS - 1) / `CBLF_CLK_PERIOD_NS)

`endif

// file: core/cblf_pkg.sv
// Types of the configuration byte loader front end
package cblf_pkg;

    // Loading mode from the three mode pins
    typedef enum logic [2:0] {
        CBLF_MODE_SERIAL = 3'b000,
        CBLF_MODE_UP     = 3'b100,
        CBLF_MODE_DOWN   = 3'b110,
        CBLF_MODE_PERIPH = 3'b101,
        CBLF_MODE_OTHER  = 3'b111
    } cblf_mode_type;

    // Loader phase
    typedef enum logic [1:0] {
        CBLF_ST_INIT = 2'b00,
        CBLF_ST_RUN  = 2'b01,
        CBLF_ST_DONE = 2'b10
    } cblf_state_type;

    // Mode pins
    typedef struct packed {
        logic mode_pin_two;
        logic mode_pin_one;
        logic mode_pin_zero;
    } cblf_mode_pins_type;

    // Microprocessor side pins
    typedef struct packed {
        logic       chip_select_low_n;
        logic       chip_select_high;
        logic       write_strobe_n;
        logic       read_strobe_n;
        logic [7:0] data;
    } cblf_host_bus_type;

    // State on the system clock
    typedef struct packed {
        cblf_state_type state;
        logic [7:0]     init_cnt;
        cblf_mode_type  mode;
        logic           prog_prev;
        logic           wr_prev;
        logic [7:0]     hold;
        logic           hold_full;
        logic [7:0]     xfer;
        logic           req;
        logic           ready;
        logic           tgl_prev;
        logic           bit_out;
        logic           bit_valid;
    } cblf_main_state_type;

    // State on the link clock
    typedef struct packed {
        logic        configuration_clock;
        logic [3:0]  div;
        logic [3:0]  bits_left;
        logic [7:0]  shift;
        logic [17:0] addr;
        logic        rclk;
        logic        bit_val;
        logic        tgl;
        logic        ack;
        logic        dout;
        logic        started;
    } cblf_link_state_type;

endpackage : cblf_pkg

// file: core/cblf_sync.sv
// Two flip-flop synchronizer
`timescale 1ns/10ps
module cblf_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] data_i,
    output logic      [WIDTH-1:0] data_o
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= '0;
            data_o <= '0;
        end else begin
            meta_q <= data_i;
            data_o <= meta_q;
        end
    end

endmodule : cblf_sync

// file: core/cblf_loader.sv
// Configuration byte loader front end: master serial, master parallel, asynchronous peripheral
//
// What this block does
// - Master parallel drives 18-bit address, captures byte at byte read strobe rise.
// - Fetched bytes are serialized least significant bit first.
// - Master up address starts at zero and increments per byte.
// - Master down address starts at all ones and decrements per byte.
// - Chain serial out changes on each falling configuration clock edge.
// - Configuration clock runs eight times the byte read strobe rate.
// - Master serial loads after power-up and again on reprogram request.
// - Initialization starts when the reset input is released, with no restart request needed.
// - Master serial samples one bit per rising configuration clock edge.
// - Config complete stays low while loading, goes high when finished.
// - After completion the serial input pin becomes a user input.
// - Peripheral write accepted only with chip select low low and high high.
// - Ready low while hold and shift registers cannot take a byte.
// - Byte moves from hold to an empty shift register at once.
// - Ready stays low until the busy shift register finishes.
// - Ready mirrored on the top data bit during a selected read.
// - Lower seven data pins are never driven in peripheral mode.
// - Mode pins select serial, master up, master down or peripheral.
// - Speed select high gives the slow clock, low the fast one.
// - Peripheral mode outputs eight configuration clocks per byte written.
`timescale 1ns/10ps
`include "cblf_regs.svh"
module cblf_loader import cblf_pkg::*; (
    input  wire logic               clock_i,
    input  wire logic               reset_n_i,
    input  wire logic               link_clk_i,
    input  wire cblf_mode_pins_type mode_pins_i,
    input  wire logic               osc_speed_select_i,
    input  wire logic               reprogram_request_n_i,
    input  wire cblf_host_bus_type  host_bus_i,
    input  wire logic [7:0]         byte_data_pins_i,
    input  wire logic               serial_data_in_i,
    input  wire logic               frame_done_i,
    output logic [17:0]             memory_address_bus_o,
    output logic                    byte_read_strobe_o,
    output logic                    configuration_clock_o,
    output logic                    chain_serial_out_o,
    output logic                    serial_bit_o,
    output logic                    serial_bit_valid_o,
    output logic                    config_complete_o,
    output logic                    loading_indicator_n_o,
    output logic                    byte_accept_ready_o,
    output logic                    ready_mirror_bit_o,
    output logic                    ready_mirror_oe_o,
    output logic                    user_input_o
);

    // ------------------------------------------------------------
    // Mode decoding
    // ------------------------------------------------------------

    // Unsupported codes fold onto one value
    function automatic cblf_mode_type cblf_decode(input logic [2:0] pins);
        cblf_mode_type m;
        m = CBLF_MODE_OTHER;
        if (pins == 3'h0) begin
            m = CBLF_MODE_SERIAL;
        end else if (pins == 3'h4) begin
            m = CBLF_MODE_UP;
        end else if (pins == 3'h6) begin
            m = CBLF_MODE_DOWN;
        end else if (pins == 3'h5) begin
            m = CBLF_MODE_PERIPH;
        end
        return m;
    endfunction : cblf_decode

    cblf_main_state_type main_q;
    cblf_main_state_type main_d;
    cblf_link_state_type link_q;
    cblf_link_state_type link_d;

    // ------------------------------------------------------------
    // Synchronizers into the system clock domain
    // ------------------------------------------------------------

    cblf_host_bus_type  m_host;
    cblf_mode_pins_type m_mode;
    logic               m_prog_n;
    logic               m_ack;
    logic               m_tgl;
    logic               m_din;

    // Pins and link handshake toggles
    cblf_sync #(.WIDTH(19)) u_sync_main (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .data_i    ({host_bus_i, mode_pins_i, reprogram_request_n_i, link_q.ack, link_q.tgl, serial_data_in_i}),
        .data_o    ({m_host, m_mode, m_prog_n, m_ack, m_tgl, m_din})
    );

    // ------------------------------------------------------------
    // Synchronizers into the link clock domain
    // ------------------------------------------------------------

    logic       l_run;
    logic [2:0] l_mode_bits;
    logic       l_slow;
    logic       l_req;
    logic       l_din;
    logic [7:0] l_data;
    logic       run_level;
    cblf_mode_type l_mode;

    // Mode is captured before run rises and stays put while running
    assign run_level = (main_q.state == CBLF_ST_RUN) && (main_q.mode != CBLF_MODE_OTHER);

    cblf_sync #(.WIDTH(15)) u_sync_link (
        .clock_i   (link_clk_i),
        .reset_n_i (reset_n_i),
        .data_i    ({run_level, main_q.mode, osc_speed_select_i, main_q.req, serial_data_in_i, byte_data_pins_i}),
        .data_o    ({l_run, l_mode_bits, l_slow, l_req, l_din, l_data})
    );

    assign l_mode = cblf_mode_type'(l_mode_bits);

    // ------------------------------------------------------------
    // System clock: phase control, hold register, bit hand-off
    // ------------------------------------------------------------

    logic periph_run;
    logic cs_active;

    assign periph_run = (main_q.state == CBLF_ST_RUN) && (main_q.mode == CBLF_MODE_PERIPH);
    assign cs_active  = !m_host.chip_select_low_n && m_host.chip_select_high;

    // Next state of the system side
    always_comb begin
        main_d           = main_q;
        main_d.prog_prev = m_prog_n;
        main_d.wr_prev   = m_host.write_strobe_n;
        main_d.tgl_prev  = m_tgl;
        main_d.bit_valid = 1'b0;

        // Phase sequence; reset enters init on its own
        unique case (main_q.state)
            CBLF_ST_INIT: begin
                if (main_q.init_cnt == 8'h00) begin
                    main_d.state = CBLF_ST_RUN;
                end else begin
                    // Mode settles a cycle ahead of run, so the link never sees run with a stale mode
                    main_d.mode     = cblf_decode(m_mode);
                    main_d.init_cnt = main_q.init_cnt - 8'h01;
                end
            end
            CBLF_ST_RUN: begin
                if (frame_done_i) begin
                    main_d.state = CBLF_ST_DONE;
                end
            end
            CBLF_ST_DONE: begin
            end
        endcase

        // Bits from the link side, one per toggle
        if (main_q.state == CBLF_ST_RUN && m_tgl != main_q.tgl_prev) begin
            main_d.bit_out   = link_q.bit_val;
            main_d.bit_valid = 1'b1;
        end

        // Hold to shift transfer when the shift side is idle
        if (periph_run && main_q.hold_full && main_q.req == m_ack) begin
            main_d.xfer      = main_q.hold;
            main_d.req       = !main_q.req;
            main_d.hold_full = 1'b0;
        end

        // Byte latched on write strobe rise with chips selected
        if (periph_run && cs_active && !main_q.wr_prev && m_host.write_strobe_n) begin
            main_d.hold      = m_host.data;
            main_d.hold_full = 1'b1;
        end

        // Falling edge of the restart request reloads
        if (main_q.prog_prev && !m_prog_n) begin
            main_d.state     = CBLF_ST_INIT;
            main_d.init_cnt  = `CBLF_INIT_CYCLES;
            main_d.hold_full = 1'b0;
        end

        // Ready follows the hold register without delay
        main_d.ready = (main_d.state == CBLF_ST_RUN) && (main_d.mode == CBLF_MODE_PERIPH)
                       && !main_d.hold_full;
    end

    // System side register
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            main_q           <= '0;
            main_q.state     <= CBLF_ST_INIT;
            main_q.init_cnt  <= `CBLF_INIT_CYCLES;
            main_q.mode      <= CBLF_MODE_OTHER;
            main_q.prog_prev <= 1'b1;
            main_q.wr_prev   <= 1'b1;
        end else begin
            main_q <= main_d;
        end
    end

    // ------------------------------------------------------------
    // Link clock: configuration clock, shifter, address counter
    // ------------------------------------------------------------

    logic clk_go;

    // Peripheral mode clocks only while a byte is pending or shifting
    assign clk_go = (l_mode != CBLF_MODE_PERIPH) || (l_req != link_q.ack) || link_q.configuration_clock;

    // Next state of the link side
    always_comb begin
        link_d = link_q;
        if (!l_run) begin
            link_d.configuration_clock      = 1'b0;
            link_d.div       = 4'h0;
            link_d.bits_left = 4'h0;
            link_d.rclk      = 1'b0;
            link_d.started   = 1'b0;
            link_d.ack       = l_req;  // Flush a stranded request
        end else if (!link_q.started) begin
            link_d.started = 1'b1;
            link_d.div     = `CBLF_ADDR_SETTLE;  // Let the first address settle
            link_d.addr    = (l_mode == CBLF_MODE_DOWN) ? `CBLF_ADDR_DOWN_START : `CBLF_ADDR_UP_START;
        end else if (clk_go) begin
            if (link_q.div != 4'h0) begin
                link_d.div = link_q.div - 4'h1;
            end else begin
                link_d.div  = (l_slow ? `CBLF_HALF_SLOW : `CBLF_HALF_FAST) - 4'h1;
                link_d.configuration_clock = !link_q.configuration_clock;
                if (!link_q.configuration_clock) begin
                    // Rising configuration clock edge
                    if (l_mode == CBLF_MODE_SERIAL) begin
                        link_d.bit_val = l_din;
                        link_d.tgl     = !link_q.tgl;
                    end else if (link_q.bits_left != 4'h0) begin
                        link_d.bit_val   = link_q.shift[0];
                        link_d.shift     = {1'b0, link_q.shift[7:1]};
                        link_d.bits_left = link_q.bits_left - 4'h1;
                        link_d.tgl       = !link_q.tgl;
                        if (link_q.bits_left == 4'h1 && l_mode == CBLF_MODE_PERIPH) begin
                            link_d.ack = !link_q.ack;
                        end
                    end else if (l_mode == CBLF_MODE_UP || l_mode == CBLF_MODE_DOWN) begin
                        link_d.bit_val   = l_data[0];
                        link_d.shift     = {1'b0, l_data[7:1]};
                        link_d.bits_left = `CBLF_BITS_PER_BYTE - 4'h1;
                        link_d.rclk      = 1'b1;
                        link_d.tgl       = !link_q.tgl;
                        link_d.addr      = (l_mode == CBLF_MODE_UP) ? link_q.addr + `CBLF_ADDR_STEP
                                                                    : link_q.addr - `CBLF_ADDR_STEP;
                    end else if (l_req != link_q.ack) begin
                        link_d.bit_val   = main_q.xfer[0];
                        link_d.shift     = {1'b0, main_q.xfer[7:1]};
                        link_d.bits_left = `CBLF_BITS_PER_BYTE - 4'h1;
                        link_d.tgl       = !link_q.tgl;
                    end
                end else begin
                    // Falling configuration clock edge
                    link_d.rclk = 1'b0;
                    link_d.dout = link_q.bit_val;
                end
            end
        end
    end

    // Link side register
    always_ff @(posedge link_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            link_q <= '0;
        end else begin
            link_q <= link_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Memory side and chain side
    assign memory_address_bus_o  = link_q.addr;
    assign byte_read_strobe_o    = link_q.rclk;
    assign configuration_clock_o = link_q.configuration_clock;
    assign chain_serial_out_o    = link_q.dout;

    // Bit stream toward the frame logic
    assign serial_bit_o       = main_q.bit_out;
    assign serial_bit_valid_o = main_q.bit_valid;

    // Phase indicators
    assign config_complete_o     = (main_q.state == CBLF_ST_DONE);
    assign loading_indicator_n_o = (main_q.state != CBLF_ST_RUN);

    // Ready and its mirror on the top data bit only
    assign byte_accept_ready_o = main_q.ready;
    assign ready_mirror_bit_o  = main_q.ready;
    assign ready_mirror_oe_o   = periph_run && cs_active && m_host.write_strobe_n
                                 && !m_host.read_strobe_n;

    // Serial input freed for user logic once complete
    assign user_input_o = config_complete_o ? m_din : 1'b0;

endmodule : cblf_loader

// file: bench/cblf_loader_sva.sv
// Checker of the loader front end pins
`timescale 1ns/10ps
module cblf_loader_sva import cblf_pkg::*; (
    input wire logic              clock_i,
    input wire logic              reset_n_i,
    input wire logic              link_clk_i,
    input wire cblf_host_bus_type host_bus_i,
    input wire logic              frame_done_i,
    input wire logic              byte_read_strobe_o,
    input wire logic              configuration_clock_o,
    input wire logic              chain_serial_out_o,
    input wire logic              config_complete_o,
    input wire logic              loading_indicator_n_o,
    input wire logic              byte_accept_ready_o,
    input wire logic              ready_mirror_bit_o,
    input wire logic              ready_mirror_oe_o,
    input wire logic              user_input_o
);
    // ----------------------------------------
    // Clock rises between byte reads
    // ----------------------------------------
    logic [3:0] rise_cnt_q;
    logic       seen_q;
    logic       clk_prev_q;
    logic       stb_prev_q;

    // Counts rises that load no byte
    always_ff @(posedge link_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rise_cnt_q <= 4'h0;
            seen_q     <= 1'b0;
            clk_prev_q <= 1'b0;
            stb_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= configuration_clock_o;
            stb_prev_q <= byte_read_strobe_o;
            if (loading_indicator_n_o) begin
                rise_cnt_q <= 4'h0;
                seen_q     <= 1'b0;
            end else if (byte_read_strobe_o && !stb_prev_q) begin
                rise_cnt_q <= 4'h0;
                seen_q     <= 1'b1;
            end else if (configuration_clock_o && !clk_prev_q) begin
                rise_cnt_q <= rise_cnt_q + 4'h1;
            end
        end
    end

    a_eight_clocks: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
        $rose(byte_read_strobe_o) && seen_q |-> rise_cnt_q == 4'h7)
        else $error("byte read not after eight clocks");
    a_chain_fall: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
        $changed(chain_serial_out_o) |-> $fell(configuration_clock_o))
        else $error("chain output moved off a falling clock");
    a_ready_drop: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $rose(host_bus_i.write_strobe_n) && !host_bus_i.chip_select_low_n && host_bus_i.chip_select_high
        && byte_accept_ready_o |-> ##[1:6] !byte_accept_ready_o)
        else $error("ready stayed high after a write");
    a_select_refuse: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        $rose(host_bus_i.write_strobe_n) && !host_bus_i.chip_select_high && byte_accept_ready_o
        |=> byte_accept_ready_o [*6])
        else $error("unselected write was taken");
    a_mirror_enable: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        ready_mirror_oe_o |-> !$past(host_bus_i.read_strobe_n, 2) && $past(host_bus_i.write_strobe_n, 2))
        else $error("mirror bit driven without a read");
    a_mirror_value: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        ready_mirror_oe_o |-> ready_mirror_bit_o == byte_accept_ready_o)
        else $error("mirror bit differs from ready");
    a_complete_low: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !loading_indicator_n_o |-> !config_complete_o)
        else $error("complete high while loading");
    a_complete_rise: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        frame_done_i && !loading_indicator_n_o |-> ##[1:5] config_complete_o)
        else $error("complete did not rise");
    a_user_idle: assert property (@(posedge clock_i) disable iff (!reset_n_i)
        !config_complete_o && !$past(config_complete_o) |-> !user_input_o)
        else $error("user input live during loading");
endmodule : cblf_loader_sva

bind cblf_loader cblf_loader_sva i_sva (.clock_i, .reset_n_i, .link_clk_i, .host_bus_i, .frame_done_i,
    .byte_read_strobe_o, .configuration_clock_o, .chain_serial_out_o, .config_complete_o,
    .loading_indicator_n_o, .byte_accept_ready_o, .ready_mirror_bit_o, .ready_mirror_oe_o, .user_input_o);

// file: bench/cblf_rom_model.sv
// Byte memory and serial memory beside the loader
`timescale 1ns/10ps
module cblf_rom_model (
    input  wire logic        link_clk_i,
    input  wire logic [17:0] memory_address_bus_i,
    input  wire logic        configuration_clock_i,
    input  wire logic        loading_indicator_n_i,
    input  wire logic        config_complete_i,
    output logic [7:0]       byte_data_o,
    output logic             serial_data_o
);
    int unsigned bit_idx = 0;
    logic        flip    = 1'b0;

    // Byte content follows the address
    assign byte_data_o = memory_address_bus_i[7:0] ^ {memory_address_bus_i[17:14], memory_address_bus_i[11:8]};

    // Pointer cleared in init, next bit after a falling clock
    always @(negedge configuration_clock_i or posedge loading_indicator_n_i) begin
        if (loading_indicator_n_i) bit_idx = 0;
        else bit_idx = bit_idx + 1;
    end

    // Released line shows a changing pattern
    always @(posedge link_clk_i) flip <= ~flip;

    // Complete high disables the serial memory
    assign serial_data_o = config_complete_i ? flip : bit_idx[0] ^ bit_idx[2];
endmodule : cblf_rom_model

// file: bench/cblf_loader_bench.sv
// Self-checking bench of the loader front end
`timescale 1ns/10ps
module cblf_loader_bench import cblf_pkg::*; ();
    logic               clk = 1'b0;
    logic               link_clk = 1'b0;
    logic               reset_n = 1'b0;
    cblf_mode_pins_type mode_pins = 3'b100;
    logic               osc_sel = 1'b0;
    logic               prog_n = 1'b1;
    cblf_host_bus_type  host = 12'hB00; // Deselected, both strobes idle high
    logic               frame_done = 1'b0;
    logic [7:0]         mem_byte;
    logic [17:0]        addr;
    logic ser_data, rd_stb, cfg_clk, chain, sbit, sval, done, ind_n, rdy, mbit, moe, uin;
    int   fails = 0;
    int   cmp_count = 0;
    int   clk_rises = 0;
    int   lo;
    int   n0;
    logic [7:0] b;
    logic got_q[$];
    logic exp_q[$];

    // Clocks with unrelated phase
    always #4 clk = ~clk;
    initial begin
        #3;
        forever #16 link_clk = ~link_clk;
    end

    cblf_loader i_dut (.clock_i(clk), .reset_n_i(reset_n), .link_clk_i(link_clk), .mode_pins_i(mode_pins),
        .osc_speed_select_i(osc_sel), .reprogram_request_n_i(prog_n), .host_bus_i(host),
        .byte_data_pins_i(mem_byte), .serial_data_in_i(ser_data), .frame_done_i(frame_done),
        .memory_address_bus_o(addr), .byte_read_strobe_o(rd_stb), .configuration_clock_o(cfg_clk),
        .chain_serial_out_o(chain), .serial_bit_o(sbit), .serial_bit_valid_o(sval),
        .config_complete_o(done), .loading_indicator_n_o(ind_n), .byte_accept_ready_o(rdy),
        .ready_mirror_bit_o(mbit), .ready_mirror_oe_o(moe), .user_input_o(uin));
    cblf_rom_model i_rom (.link_clk_i(link_clk), .memory_address_bus_i(addr), .configuration_clock_i(cfg_clk),
        .loading_indicator_n_i(ind_n), .config_complete_i(done), .byte_data_o(mem_byte), .serial_data_o(ser_data));

    // Gathers bits and clock rises
    always @(posedge clk) if (sval === 1'b1) got_q.push_back(sbit);
    always @(posedge cfg_clk) clk_rises++;

    function automatic logic [7:0] mem_f(input logic [17:0] a);
        return a[7:0] ^ {a[17:14], a[11:8]};
    endfunction : mem_f

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic push_byte(input logic [7:0] v);
        for (int i = 0; i < 8; i++) exp_q.push_back(v[i]);
    endtask : push_byte

    // Waits for n bits and compares them in order
    task automatic cmp_bits(input int n);
        int k;
        k = 0;
        while (got_q.size() < n && k < 20000) begin
            @(posedge clk);
            k++;
        end
        check(got_q.size() >= n, 1);
        for (int i = 0; i < n; i++) check(got_q[i], exp_q[i]);
    endtask : cmp_bits

    // Clock rises over 4096 ns
    task automatic rate(input int e);
        int r;
        r = clk_rises;
        repeat (512) @(posedge clk);
        check((clk_rises - r) inside {[e - 1:e + 1]}, 1);
    endtask : rate

    task automatic restart(input cblf_mode_pins_type m, input logic s);
        @(posedge clk);
        mode_pins <= m;
        osc_sel   <= s;
        prog_n    <= 1'b0;
        repeat (63) @(posedge clk);
        prog_n <= 1'b1;
        repeat (8) @(posedge clk);
        got_q.delete();
        exp_q.delete();
    endtask : restart

    // One host write, returns cycles until ready again
    task automatic host_write(input logic [7:0] v, input logic hi, input logic keep, output int t);
        int k;
        k = 0;
        @(posedge clk);
        while (rdy !== 1'b1 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        host.chip_select_low_n <= 1'b0;
        host.chip_select_high  <= hi;
        host.data              <= v;
        repeat (3) @(posedge clk);
        host.write_strobe_n <= 1'b0;
        repeat (4) @(posedge clk);
        host.write_strobe_n <= 1'b1;
        k = 0;
        while (k < 8 && rdy === 1'b1) begin
            @(posedge clk);
            k++;
        end
        while (k < 3000 && rdy !== 1'b1) begin
            @(posedge clk);
            k++;
        end
        t = k;
        if (!keep) host.chip_select_low_n <= 1'b1;
    endtask : host_write

    // Hang guard
    initial begin
        #200us;
        fails++;
        close_out();
    end

    // Main sequence
    initial begin
        void'($urandom(32'h6234));
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (140) @(posedge clk);
        check(ind_n, 0);
        for (int i = 0; i < 3; i++) push_byte(mem_f(18'h00000 + 18'(i)));
        cmp_bits(24);
        rate(64);
        restart(3'b110, 1'b0);
        for (int i = 0; i < 3; i++) push_byte(mem_f(18'h3FFFF - 18'(i)));
        cmp_bits(24);
        restart(3'b101, 1'b1);
        n0 = clk_rises;
        for (int i = 0; i < 3; i++) begin
            b = 8'($urandom);
            push_byte(b);
            host_write(b, 1'b1, i > 0, lo);
            check(lo < 100, i == 0);
        end
        host_write(8'($urandom), 1'b0, 1'b1, lo);
        repeat (700) @(posedge clk);
        check(clk_rises - n0, 24);
        check(got_q.size(), 24);
        cmp_bits(24);
        host.chip_select_high <= 1'b1;
        host.read_strobe_n    <= 1'b0;
        repeat (4) @(posedge clk);
        check({moe, mbit}, 2'h3);
        host.chip_select_high <= 1'b0;
        repeat (4) @(posedge clk);
        check(moe, 0);
        host.read_strobe_n <= 1'b1;
        restart(3'b000, 1'b1);
        for (int i = 0; i < 12; i++) exp_q.push_back(i[0] ^ i[2]);
        cmp_bits(12);
        rate(8);
        check(done, 0);
        frame_done <= 1'b1;
        repeat (8) @(posedge clk);
        check({done, ind_n}, 2'h3);
        b[0] = uin;
        repeat (4) @(posedge clk);
        check(uin, !b[0]);
        close_out();
    end
endmodule : cblf_loader_bench
